// ===== core/secr_pkg.sv
package secr_pkg;
    // Register word indices; byte address is four times the index.
    localparam logic [7:0] IDX_MISC_ONE = 8'h16;
    localparam logic [7:0] IDX_FIFO_CTL = 8'h17;
    localparam logic [7:0] IDX_CHIP_TWO = 8'h1e;
    // Socket select lives in address bit 8 (socket B at plus 0x100).
    localparam int SOCK_BIT = 8;
    // Misc control one field positions.
    localparam int M1_TRISTATE = 0;
    localparam int M1_SUPPLY_3V = 1;
    localparam int M1_PULSE_MGMT = 2;
    localparam int M1_PULSE_SYS = 3;
    localparam int M1_AUDIO = 4;
    localparam int M1_INPACK = 7;
    // FIFO control field positions.
    localparam int FC_STATUS = 7;
    // Chip control two field positions.
    localparam int C2_EXT_CLK = 0;
    localparam int C2_LOW_POWER = 1;
    localparam int C2_SUSPEND = 2;
    localparam int C2_RING_SEL = 7;
    // Reset values.
    localparam logic [7:0] RST_MISC_ONE = 8'h00;
    localparam logic [6:0] RST_FIFO_SCRATCH = 7'h00;
    localparam logic [7:0] RST_CHIP_TWO = 8'h02;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
    // Pulse train length for sharable interrupt pulses, in system clocks.
    localparam int PULSE_NS = 200;
    localparam int CLK_NS = 20;
    localparam logic [3:0] PULSE_CYC = 4'(PULSE_NS / CLK_NS);

    typedef struct packed {
        logic [7:0] misc_one;
        logic [6:0] fifo_scratch;
    } secr_sock_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_PULSE = 3'b010,
        ST_WAIT = 3'b100
    } secr_pulse_e;
endpackage

// ===== core/secr_pulser.sv
`timescale 1ns/1ps
// Turns an interrupt level into a level or, while the clock runs, a sharable high-going pulse per assertion.
module secr_pulser (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // Control and request
    input wire logic pulse_mode_in,
    input wire logic clk_run_in,
    input wire logic irq_in,
    // Interrupt drive
    output logic irq_out
);
    typedef struct packed {
        secr_pkg::secr_pulse_e st;
        logic [3:0] cnt;
        logic irq;
    } secr_pl_s;

    secr_pl_s s_r;
    secr_pl_s s_nxt;

    // Pulse stays active for a fixed count, then waits until the request drops.
    always_comb
    begin
        s_nxt = s_r;
        case (s_r.st)
            secr_pkg::ST_IDLE:
            begin
                s_nxt.irq = 1'b0;
                if (irq_in && clk_run_in && pulse_mode_in)
                begin
                    s_nxt.st = secr_pkg::ST_PULSE;
                    s_nxt.cnt = secr_pkg::PULSE_CYC;
                    s_nxt.irq = 1'b1;
                end
                else if (irq_in && !pulse_mode_in)
                begin
                    s_nxt.irq = 1'b1;
                end
            end
            secr_pkg::ST_PULSE:
            begin
                s_nxt.cnt = s_r.cnt - 4'h1;
                if (s_r.cnt == 4'h1)
                begin
                    s_nxt.st = secr_pkg::ST_WAIT;
                    s_nxt.irq = 1'b0;
                end
            end
            secr_pkg::ST_WAIT:
            begin
                if (!irq_in)
                begin
                    s_nxt.st = secr_pkg::ST_IDLE;
                end
            end
            default:
            begin
                s_nxt.st = secr_pkg::ST_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            s_r <= '{st: secr_pkg::ST_IDLE, cnt: 4'h0, irq: 1'b0};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign irq_out = s_r.irq;
endmodule

// ===== core/secr_regs.sv
`timescale 1ns/1ps
// Contract
// - Tristate bit floats socket address lines 25..4, nothing else changes.
// - Tristate bit acts only while extended control bit 7 is one.
// - With card power on, supply bit picks 3.3 V enable or 5 V enable.
// - Management interrupt goes out as level, or as pulse when socket A bit 2 set and the internal clock runs.
// - Card interrupts go out as level, or as pulses when bit 3 set and the internal clock runs.
// - Audio output floats when bit clear, else XOR of enabled socket audio.
// - Input-acknowledge bit is stored and read back with no effect.
// - FIFO status reads one when empty, zero when holding data; one after reset.
// - Writing one to FIFO status flushes the FIFO; zero does nothing.
// - FIFO flushes on reset pin low, card removal or supply power off.
// - External clock bit one: external pin divided by two times sockets.
// - External clock bit zero: PCI clock divided by two times sockets.
// - Low-power dynamic bit stops internal clock while idle; resets to one.
// - Suspend stops clock, enables low-power modes, refuses socket access.
// - Ring select makes interrupt-15 pin a ring output on status fall.
module secr_regs #(
    parameter int NSOCK = 2
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Extended control and power state per socket
    input wire logic ext_tristate_en_in,
    input wire logic [NSOCK-1:0] card_power_in,
    input wire logic [NSOCK-1:0] card_present_in,
    // FIFO occupancy and activity from the socket datapath
    input wire logic [NSOCK-1:0] fifo_has_data_in,
    output logic [NSOCK-1:0] fifo_flush_out,
    input wire logic busy_in,
    // Clock sources; ext clock arrives on the shared interrupt-14 pin
    input wire logic pci_clk_in,
    input wire logic irq_alt_ext_clock_pin_in,
    output logic sock_clk_out,
    output logic sock_access_en_out,
    output logic low_power_out,
    // Socket address lines and power enables
    output logic [NSOCK-1:0] addr_oe_out,
    output logic [NSOCK-1:0] vcc3_en_out,
    output logic [NSOCK-1:0] vcc5_en_out,
    // Interrupt requests and pin drive
    input wire logic mgmt_irq_in,
    input wire logic [NSOCK-1:0] card_irq_in,
    output logic mgmt_irq_out,
    output logic [NSOCK-1:0] system_interrupt_pin_out,
    // Audio
    input wire logic [NSOCK-1:0] card_audio_in_n_in,
    output logic audio_out_n_out,
    output logic audio_oe_out,
    // Ring indicate
    input wire logic [NSOCK-1:0] card_status_change_in,
    output logic irq_alt_ring_out_pin_n_out,
    output logic ring_mode_out
);
    typedef struct packed {
        secr_pkg::secr_sock_s [NSOCK-1:0] sock;
        logic [7:0] chip;
        logic ready;
        logic err;
        logic [31:0] rdata;
        logic [NSOCK-1:0] flush;
        logic [NSOCK-1:0] sts_q;
        logic ring_n;
        logic [NSOCK-1:0] addr_oe;
        logic [NSOCK-1:0] v3;
        logic [NSOCK-1:0] v5;
        logic aud;
        logic aud_oe;
        logic div_pci;
        logic div_ext;
        logic pci_q;
        logic ext_q;
        logic sclk;
        logic run;
        logic lp;
        logic ring_mode;
        logic acc_en;
    } secr_st_s;

    secr_st_s s_r;
    secr_st_s s_nxt;
    logic [NSOCK:0] irq_lvl;
    logic [NSOCK:0] irq_pin;
    logic [NSOCK:0] irq_pm;

    // Socket select position within the word index.
    localparam int SOCK_IDX_BIT = secr_pkg::SOCK_BIT - 2;

    // Splits an address into a register index, ignoring the socket bit.
    function automatic logic [7:0] reg_index(input logic [11:0] a);
        reg_index = a[9:2];
        reg_index[SOCK_IDX_BIT] = 1'b0;
    endfunction

    // One pulser per socket plus one for management; index NSOCK is management.
    assign irq_lvl = {mgmt_irq_in, card_irq_in};
    genvar g;
    generate
        for (g = 0; g <= NSOCK; g++)
        begin : g_pulse
            if (g == NSOCK)
            begin : g_mgmt
                assign irq_pm[g] = s_r.sock[0].misc_one[secr_pkg::M1_PULSE_MGMT];
            end
            else
            begin : g_card
                assign irq_pm[g] = s_r.sock[g].misc_one[secr_pkg::M1_PULSE_SYS];
            end
            secr_pulser u_pulser (
                .clk_in(clk_in),
                .rst_b_in(rst_b_in),
                .pulse_mode_in(irq_pm[g]),
                .clk_run_in(s_r.run),
                .irq_in(irq_lvl[g]),
                .irq_out(irq_pin[g])
            );
        end
    endgenerate

    // Register access, FIFO flush, pin control and socket clock generation.
    always_comb
    begin
        logic acc;
        logic [7:0] idx;
        logic sel;
        logic hit;
        logic suspend;
        logic active;
        acc = 1'b0;
        idx = 8'h00;
        sel = 1'b0;
        hit = 1'b0;
        suspend = 1'b0;
        active = 1'b0;
        s_nxt = s_r;
        acc = psel_in && penable_in && !s_r.ready;
        idx = reg_index(paddr_in);
        sel = paddr_in[secr_pkg::SOCK_BIT];
        hit = (idx == secr_pkg::IDX_MISC_ONE) || (idx == secr_pkg::IDX_FIFO_CTL) ||
              (idx == secr_pkg::IDX_CHIP_TWO);
        s_nxt.ready = acc;
        s_nxt.err = acc && !hit;
        s_nxt.flush = '0;
        s_nxt.rdata = secr_pkg::RDATA_ZERO;
        if (acc && pwrite_in)
        begin
            case (idx)
                // Stores every bit including inpack and scratch bits.
                secr_pkg::IDX_MISC_ONE: s_nxt.sock[sel].misc_one = pwdata_in[7:0];
                secr_pkg::IDX_FIFO_CTL:
                begin
                    s_nxt.sock[sel].fifo_scratch = pwdata_in[6:0];
                    s_nxt.flush[sel] = pwdata_in[secr_pkg::FC_STATUS];
                end
                secr_pkg::IDX_CHIP_TWO: s_nxt.chip = pwdata_in[7:0];
                default: s_nxt.err = 1'b1;
            endcase
        end
        else if (acc)
        begin
            case (idx)
                secr_pkg::IDX_MISC_ONE: s_nxt.rdata = {24'h00_0000, s_r.sock[sel].misc_one};
                secr_pkg::IDX_FIFO_CTL:
                    s_nxt.rdata = {24'h00_0000, !fifo_has_data_in[sel], s_r.sock[sel].fifo_scratch};
                secr_pkg::IDX_CHIP_TWO: s_nxt.rdata = {24'h00_0000, s_r.chip};
                default: s_nxt.rdata = secr_pkg::RDATA_ZERO;
            endcase
        end
        // Flushes from reset pin are covered by rst_b_in setting every flush bit.
        for (int i = 0; i < NSOCK; i++)
        begin
            if (!card_present_in[i] || !card_power_in[i])
            begin
                s_nxt.flush[i] = 1'b1;
            end
            s_nxt.addr_oe[i] = !(s_r.sock[i].misc_one[secr_pkg::M1_TRISTATE] && ext_tristate_en_in);
            s_nxt.v3[i] = card_power_in[i] && s_r.sock[i].misc_one[secr_pkg::M1_SUPPLY_3V];
            s_nxt.v5[i] = card_power_in[i] && !s_r.sock[i].misc_one[secr_pkg::M1_SUPPLY_3V];
        end
        // Audio is an XOR of active-low card inputs of sockets with audio on.
        s_nxt.aud = 1'b1;
        s_nxt.aud_oe = 1'b0;
        for (int i = 0; i < NSOCK; i++)
        begin
            if (s_r.sock[i].misc_one[secr_pkg::M1_AUDIO])
            begin
                s_nxt.aud = s_nxt.aud ^ !card_audio_in_n_in[i];
                s_nxt.aud_oe = 1'b1;
            end
        end
        // Ring indicate: low on a falling status-change edge of any socket.
        s_nxt.sts_q = card_status_change_in;
        s_nxt.ring_mode = s_nxt.chip[secr_pkg::C2_RING_SEL];
        s_nxt.ring_n = !(s_r.chip[secr_pkg::C2_RING_SEL] && |(s_r.sts_q & ~card_status_change_in));
        // Sources are sampled, so the divided clock toggles on each rising source edge.
        suspend = s_r.chip[secr_pkg::C2_SUSPEND];
        active = busy_in || |fifo_has_data_in;
        s_nxt.run = !suspend && (active || !s_r.chip[secr_pkg::C2_LOW_POWER]);
        s_nxt.lp = suspend || (s_r.chip[secr_pkg::C2_LOW_POWER] && !active);
        // Registered from the next chip value so the pin flips with the register itself.
        s_nxt.acc_en = !s_nxt.chip[secr_pkg::C2_SUSPEND];
        s_nxt.pci_q = pci_clk_in;
        s_nxt.ext_q = irq_alt_ext_clock_pin_in;
        if (pci_clk_in && !s_r.pci_q)
        begin
            s_nxt.div_pci = !s_r.div_pci;
        end
        if (irq_alt_ext_clock_pin_in && !s_r.ext_q)
        begin
            s_nxt.div_ext = !s_r.div_ext;
        end
        if (s_r.run)
        begin
            s_nxt.sclk = s_r.chip[secr_pkg::C2_EXT_CLK] ? s_r.div_ext : s_r.div_pci;
        end
    end

    // State register; reset clears the rest, loads register reset values and idle pin levels, and leaves FIFOs flushed.
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            s_r <= '0;
            for (int i = 0; i < NSOCK; i++)
            begin
                s_r.sock[i].misc_one <= secr_pkg::RST_MISC_ONE;
                s_r.sock[i].fifo_scratch <= secr_pkg::RST_FIFO_SCRATCH;
            end
            s_r.chip <= secr_pkg::RST_CHIP_TWO;
            s_r.flush <= '1;
            s_r.ring_n <= 1'b1;
            s_r.aud <= 1'b1;
            s_r.addr_oe <= '1;
            s_r.acc_en <= 1'b1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // Interrupt pins are registered once more so every output leaves a flip-flop.
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            system_interrupt_pin_out <= '0;
            mgmt_irq_out <= 1'b0;
        end
        else
        begin
            system_interrupt_pin_out <= irq_pin[NSOCK-1:0];
            mgmt_irq_out <= irq_pin[NSOCK];
        end
    end

    assign prdata_out = s_r.rdata;
    assign pready_out = s_r.ready;
    assign pslverr_out = s_r.err;
    assign fifo_flush_out = s_r.flush;
    assign sock_clk_out = s_r.sclk;
    assign sock_access_en_out = s_r.acc_en;
    assign low_power_out = s_r.lp;
    assign addr_oe_out = s_r.addr_oe;
    assign vcc3_en_out = s_r.v3;
    assign vcc5_en_out = s_r.v5;
    assign audio_out_n_out = s_r.aud;
    assign audio_oe_out = s_r.aud_oe;
    assign irq_alt_ring_out_pin_n_out = s_r.ring_n;
    assign ring_mode_out = s_r.ring_mode;
endmodule

// ===== sim/secr_card_model.sv
`timescale 1ns/1ps
// Card side stand-in: write FIFO occupancy and the two slow clock sources.
module secr_card_model (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // Bench steering and block flush
    input wire logic [1:0] fill_req_in,
    input wire logic [1:0] src_en_in,
    input wire logic [1:0] fifo_flush_in,
    // Card side outputs
    output logic [1:0] fifo_has_data_out,
    output logic pci_clk_out,
    output logic ext_clk_out
);
    logic [1:0] div_r = 2'd0;
    logic [1:0] data_r = 2'b00;
    logic [1:0] clk_r = 2'b00;
    assign fifo_has_data_out = data_r;
    assign pci_clk_out = clk_r[0];
    assign ext_clk_out = clk_r[1];

    // A flush empties the FIFO at once; a disabled source stands still low.
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            div_r <= 2'd0;
            data_r <= 2'b00;
            clk_r <= 2'b00;
        end
        else
        begin
            div_r <= div_r + 2'd1;
            data_r <= (data_r | fill_req_in) & ~fifo_flush_in;
            if (div_r == 2'd3)
            begin
                clk_r <= src_en_in & ~clk_r;
            end
        end
    end
endmodule

// ===== sim/secr_regs_monitor.sv
`timescale 1ns/1ps
// Watches the register block pins; every property except chk_flush_reset is disabled while reset is low.
module secr_regs_monitor #(
    parameter int NSOCK = 2
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // APB handshake
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pready_out,
    input wire logic pslverr_out,
    // Socket pins
    input wire logic [NSOCK-1:0] card_power_in,
    input wire logic [NSOCK-1:0] card_present_in,
    input wire logic [NSOCK-1:0] fifo_flush_out,
    input wire logic [NSOCK-1:0] vcc3_en_out,
    input wire logic [NSOCK-1:0] vcc5_en_out,
    input wire logic [NSOCK-1:0] card_status_change_in,
    input wire logic ring_mode_out,
    input wire logic irq_alt_ring_out_pin_n_out,
    input wire logic [NSOCK-1:0] card_irq_in,
    input wire logic [NSOCK-1:0] system_interrupt_pin_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);

    // An access is taken once; the answer is one pulse a cycle later.
    sequence s_taken;
        psel_in && penable_in && !pready_out;
    endsequence
    sequence s_answer;
        pready_out ##1 !pready_out;
    endsequence

    chk_apb_answer: assert property (s_taken |=> s_answer)
        else $error("access not answered one cycle after it was taken");
    chk_err_ready: assert property (pslverr_out |-> pready_out)
        else $error("error flag without ready");
    chk_flush_reset: assert property (disable iff (1'b0) !rst_b_in |=> fifo_flush_out == '1)
        else $error("fifo not flushed in reset");
    chk_flush_absent: assert property (!card_present_in[0] [*2] |-> fifo_flush_out[0])
        else $error("fifo not flushed with card absent");
    chk_flush_power: assert property (!card_power_in[1] [*2] |-> fifo_flush_out[1])
        else $error("fifo not flushed with power off");
    chk_supply_off: assert property (!card_power_in[1] [*2] |-> !vcc3_en_out[1] && !vcc5_en_out[1])
        else $error("supply enabled without card power");
    chk_ring_pulse: assert property (ring_mode_out && $fell(card_status_change_in[0]) |-> ##[1:3] !irq_alt_ring_out_pin_n_out)
        else $error("no ring pulse after status fall");
    chk_ring_quiet: assert property (!ring_mode_out [*3] |-> irq_alt_ring_out_pin_n_out)
        else $error("ring output active with ring select clear");
    chk_irq_cause: assert property ($rose(system_interrupt_pin_out[1]) |-> $past(card_irq_in[1], 2))
        else $error("interrupt pin rose without a request");
endmodule

// ===== sim/secr_regs_tb.sv
`timescale 1ns/1ps
module secr_regs_tb;
    logic clk_in, rst_b_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out, err;
    logic ext_tristate_en_in, busy_in, pci_clk_in, irq_alt_ext_clock_pin_in, sock_clk_out;
    logic sock_access_en_out, low_power_out, mgmt_irq_in, mgmt_irq_out, audio_out_n_out;
    logic audio_oe_out, irq_alt_ring_out_pin_n_out, ring_mode_out;
    logic [11:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out, rd;
    logic [1:0] card_power_in, card_present_in, fifo_has_data_in, fifo_flush_out, addr_oe_out;
    logic [1:0] vcc3_en_out, vcc5_en_out, card_irq_in, system_interrupt_pin_out, card_audio_in_n_in;
    logic [1:0] card_status_change_in, fill_req, src_en;
    int mismatches, n_checks, cyc;

    // Block under test with both sockets.
    secr_regs dut_u (.clk_in, .rst_b_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
        .prdata_out, .pready_out, .pslverr_out, .ext_tristate_en_in, .card_power_in, .card_present_in,
        .fifo_has_data_in, .fifo_flush_out, .busy_in, .pci_clk_in, .irq_alt_ext_clock_pin_in, .sock_clk_out,
        .sock_access_en_out, .low_power_out, .addr_oe_out, .vcc3_en_out, .vcc5_en_out, .mgmt_irq_in,
        .card_irq_in, .mgmt_irq_out, .system_interrupt_pin_out, .card_audio_in_n_in, .audio_out_n_out,
        .audio_oe_out, .card_status_change_in, .irq_alt_ring_out_pin_n_out, .ring_mode_out);
    // Far side: FIFO fill state and the clock sources.
    secr_card_model card_u (.clk_in, .rst_b_in, .fill_req_in(fill_req), .src_en_in(src_en),
        .fifo_flush_in(fifo_flush_out), .fifo_has_data_out(fifo_has_data_in), .pci_clk_out(pci_clk_in),
        .ext_clk_out(irq_alt_ext_clock_pin_in));

    // Free running 50 MHz clock.
    initial
    begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    // A hang counts as a mismatch and ends the run.
    always @(posedge clk_in)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer; waits for ready (only the bench timeout ends a hang), then an idle cycle.
    task automatic apb(input logic wr_en, input logic [11:0] a, input logic [31:0] d);
        psel_in <= 1'b1;
        pwrite_in <= wr_en;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do
        begin
            @(posedge clk_in);
        end
        while (pready_out !== 1'b1);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge clk_in);
    endtask

    function automatic logic [11:0] ad(input logic s, input logic [7:0] i);
        return {3'b000, s, 8'h00} | {2'b00, i, 2'b00};
    endfunction

    task automatic wr(input logic s, input logic [7:0] i, input logic [7:0] d);
        apb(1'b1, ad(s, i), {24'h00_0000, d});
    endtask

    task automatic rdc(input logic s, input logic [7:0] i, input logic [7:0] exp);
        apb(1'b0, ad(s, i), 32'h0000_0000);
        check($sformatf("reg %h", ad(s, i)), rd, {24'h00_0000, exp});
    endtask

    task automatic t_reset();
        rdc(1'b0, secr_pkg::IDX_MISC_ONE, 8'h00);
        rdc(1'b1, secr_pkg::IDX_FIFO_CTL, 8'h80);
        rdc(1'b0, secr_pkg::IDX_CHIP_TWO, 8'h02);
        apb(1'b0, ad(1'b0, 8'h20), 32'h0000_0000);
        check("unmapped error", err, 32'h0000_0001);
    endtask

    task automatic t_fifo();
        wr(1'b0, secr_pkg::IDX_MISC_ONE, 8'he0);
        rdc(1'b0, secr_pkg::IDX_MISC_ONE, 8'he0);
        rdc(1'b1, secr_pkg::IDX_MISC_ONE, 8'h00);
        wr(1'b1, secr_pkg::IDX_FIFO_CTL, 8'h7f);
        rdc(1'b1, secr_pkg::IDX_FIFO_CTL, 8'hff);
        fill_req <= 2'b11;
        @(posedge clk_in);
        fill_req <= 2'b00;
        rdc(1'b1, secr_pkg::IDX_FIFO_CTL, 8'h7f);
        wr(1'b0, secr_pkg::IDX_FIFO_CTL, 8'h00);
        rdc(1'b0, secr_pkg::IDX_FIFO_CTL, 8'h00);
        wr(1'b1, secr_pkg::IDX_FIFO_CTL, 8'hff);
        rdc(1'b1, secr_pkg::IDX_FIFO_CTL, 8'hff);
        card_present_in <= 2'b10;
        card_power_in <= 2'b01;
        repeat (4) @(posedge clk_in);
        card_present_in <= 2'b11;
        card_power_in <= 2'b11;
        rdc(1'b0, secr_pkg::IDX_FIFO_CTL, 8'h80);
        wr(1'b1, secr_pkg::IDX_CHIP_TWO, 8'h00);
        rdc(1'b0, secr_pkg::IDX_CHIP_TWO, 8'h00);
    endtask

    task automatic t_pins();
        wr(1'b0, secr_pkg::IDX_MISC_ONE, 8'h01);
        check("addr drive", addr_oe_out, 32'h0000_0003);
        ext_tristate_en_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        check("addr drive", addr_oe_out, 32'h0000_0002);
        wr(1'b0, secr_pkg::IDX_MISC_ONE, 8'h02);
        check("vcc3", vcc3_en_out, 32'h0000_0001);
        check("vcc5", vcc5_en_out, 32'h0000_0002);
        check("audio oe", audio_oe_out, 32'h0000_0000);
        wr(1'b0, secr_pkg::IDX_MISC_ONE, 8'h10);
        wr(1'b1, secr_pkg::IDX_MISC_ONE, 8'h10);
        for (int v = 0; v < 4; v++)
        begin
            card_audio_in_n_in <= 2'(v);
            repeat (3) @(posedge clk_in);
            check("audio oe", audio_oe_out, 32'h0000_0001);
            check("audio", audio_out_n_out, {31'h0000_0000, ~^(2'(v))});
        end
    endtask

    // Pulse modes need the internal clock running, so low-power dynamic is off here.
    task automatic pulse_len(input logic m, input logic [31:0] exp);
        logic [31:0] hi;
        hi = 32'h0000_0000;
        repeat (20)
        begin
            @(posedge clk_in);
            hi += m ? mgmt_irq_out : system_interrupt_pin_out[1];
        end
        check("pulse length", hi, exp);
    endtask

    task automatic t_irq();
        mgmt_irq_in <= 1'b1;
        card_irq_in <= 2'b10;
        repeat (4) @(posedge clk_in);
        check("mgmt level", mgmt_irq_out, 32'h0000_0001);
        check("card level", system_interrupt_pin_out, 32'h0000_0002);
        mgmt_irq_in <= 1'b0;
        card_irq_in <= 2'b00;
        wr(1'b0, secr_pkg::IDX_MISC_ONE, 8'h04);
        wr(1'b1, secr_pkg::IDX_MISC_ONE, 8'h08);
        mgmt_irq_in <= 1'b1;
        pulse_len(1'b1, {28'h000_0000, secr_pkg::PULSE_CYC});
        card_irq_in <= 2'b10;
        pulse_len(1'b0, {28'h000_0000, secr_pkg::PULSE_CYC});
        mgmt_irq_in <= 1'b0;
        card_irq_in <= 2'b00;
    endtask

    task automatic t_ring_susp();
        logic seen;
        seen = 1'b0;
        wr(1'b0, secr_pkg::IDX_CHIP_TWO, 8'h80);
        check("ring mode", ring_mode_out, 32'h0000_0001);
        card_status_change_in <= 2'b10;
        repeat (6)
        begin
            @(posedge clk_in);
            seen |= (irq_alt_ring_out_pin_n_out === 1'b0);
        end
        check("ring pulse", seen, 32'h0000_0001);
        wr(1'b0, secr_pkg::IDX_CHIP_TWO, 8'h04);
        check("access", sock_access_en_out, 32'h0000_0000);
        check("low power", low_power_out, 32'h0000_0001);
        wr(1'b0, secr_pkg::IDX_CHIP_TWO, 8'h00);
        check("access", sock_access_en_out, 32'h0000_0001);
    endtask

    // Counts socket clock toggles while one source runs at an eighth of the system clock.
    task automatic t_clk(input logic [1:0] en, input logic [7:0] c2, input logic run);
        int n;
        logic p;
        n = 0;
        wr(1'b0, secr_pkg::IDX_CHIP_TWO, c2);
        src_en <= en;
        p = sock_clk_out;
        repeat (64)
        begin
            @(posedge clk_in);
            n += int'(sock_clk_out !== p);
            p = sock_clk_out;
        end
        check("socket clock", {31'h0000_0000, n >= 6 && n <= 10}, {31'h0000_0000, run});
        src_en <= 2'b00;
    endtask

    // Reset for 12 cycles, then the scenarios in order.
    initial
    begin
        {rst_b_in, psel_in, penable_in, pwrite_in, ext_tristate_en_in, busy_in, mgmt_irq_in} = 7'h00;
        {paddr_in, pwdata_in, card_irq_in, fill_req, src_en} = 50'h0_0000_0000_0000;
        {card_power_in, card_present_in, card_audio_in_n_in, card_status_change_in} = 8'hff;
        repeat (12) @(posedge clk_in);
        rst_b_in <= 1'b1;
        @(posedge clk_in);
        t_reset();
        t_fifo();
        t_pins();
        t_irq();
        t_ring_susp();
        t_clk(2'b01, 8'h00, 1'b1);
        t_clk(2'b10, 8'h01, 1'b1);
        t_clk(2'b01, 8'h01, 1'b0);
        t_clk(2'b01, 8'h02, 1'b0);
        busy_in <= 1'b1;
        t_clk(2'b01, 8'h02, 1'b1);
        finish_test();
    end
endmodule

bind secr_regs secr_regs_monitor #(.NSOCK(NSOCK)) mon_u (.clk_in, .rst_b_in, .psel_in, .penable_in,
    .pready_out, .pslverr_out, .card_power_in, .card_present_in, .fifo_flush_out, .vcc3_en_out,
    .vcc5_en_out, .card_status_change_in, .ring_mode_out, .irq_alt_ring_out_pin_n_out, .card_irq_in,
    .system_interrupt_pin_out);
